// File: intc_pkg.sv
`default_nettype none
package intc_pkg;
  localparam int NUM_SRC = 12;
  localparam int LVL_W = 2;
  // level encodings
  localparam logic [1:0] LVL_URGENT = 2'h1;
  localparam logic [1:0] LVL_NEXT = 2'h2;
  localparam logic [1:0] LVL_OFF = 2'h3;
  localparam logic [1:0] LVL_RESET = 2'h3;
  // current-level field after reset: every level below 3 accepted
  localparam logic [1:0] CUR_LVL_RESET = 2'h3;
  // vector table top pair and step between pairs
  localparam logic [15:0] VEC_TOP = 16'hfffa;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  // source numbers
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_TMR0 = 3;
  localparam int SRC_TMR1 = 4;
  localparam int SRC_SER = 8;
  localparam int SRC_ADC = 9;
  localparam int SRC_ITV = 10;
  localparam int SRC_WATCH = 11;
  localparam logic [11:0] SRC_USED = 12'hf1b;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PSW_RESET = 16'h0000;
  localparam int IL_LSB = 12;
  localparam int IFLAG_BIT = 11;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_PUSH_PC = 3'b001,
    ST_PUSH_PSW = 3'b010,
    ST_VECTOR = 3'b011,
    ST_POP_PSW = 3'b100,
    ST_POP_PC = 3'b101
  } cpu_state_type;
endpackage
`default_nettype wire

// File: intc_arbiter.sv
`default_nettype none
module intc_arbiter #(
  parameter int N = intc_pkg::NUM_SRC
) (
  input wire logic [N-1:0] req_in,
  input wire logic [2*N-1:0] lvl_in,
  output logic valid_out,
  output logic [3:0] src_out,
  output logic [1:0] lvl_out
);
  import intc_pkg::*;
  logic [1:0] best_lvl [N:0];
  logic [3:0] best_src [N:0];
  logic best_v [N:0];
  assign best_lvl[N] = LVL_OFF;
  assign best_src[N] = 4'h0;
  assign best_v[N] = 1'b0;
  // a stage takes over from the higher-numbered stages on an equal level,
  // so the lowest source number wins ties
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_arb
      logic [1:0] l;
      logic take;
      assign l = lvl_in[2*g +: 2];
      assign take = req_in[g] && (l != LVL_OFF) && (!best_v[g+1] || l <= best_lvl[g+1]);
      assign best_v[g] = take || best_v[g+1];
      assign best_lvl[g] = take ? l : best_lvl[g+1];
      assign best_src[g] = take ? 4'(g) : best_src[g+1];
    end
  endgenerate
  assign valid_out = best_v[0];
  assign src_out = best_src[0];
  assign lvl_out = best_lvl[0];
endmodule
`default_nettype wire

// File: priority_interrupt_controller.sv
`default_nettype none
module priority_interrupt_controller
  import intc_pkg::*;
#(
  parameter int N = intc_pkg::NUM_SRC
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [N-1:0] PERIPH_REQ_IN,
  input wire logic EXT0_FLAG_IN,
  input wire logic EXT0_ENABLE_IN,
  input wire logic EXT_PIN1_REQUEST_FLAG_IN,
  input wire logic EXT_PIN1_REQUEST_ENABLE_IN,
  input wire logic MAIN_STOP_IN,
  input wire logic [7:0] LEVEL_SELECT_REG_A_IN,
  input wire logic [7:0] LEVEL_SELECT_REG_B_IN,
  input wire logic [7:0] LEVEL_SELECT_REG_C_IN,
  input wire logic LEVEL_WRITE_IN,
  input wire logic INSTR_BOUNDARY_IN,
  input wire logic RETURN_FROM_INTERRUPT_OP_IN,
  input wire logic [15:0] PC_IN,
  input wire logic [15:0] PROGRAM_STATUS_WORD_IN,
  input wire logic [15:0] STACK_RDATA_IN,
  output logic SUSPEND_OUT,
  output logic STACK_WRITE_OUT,
  output logic STACK_READ_OUT,
  output logic [15:0] STACK_WDATA_OUT,
  output logic LOAD_PC_OUT,
  output logic [15:0] PC_OUT,
  output logic LOAD_PSW_OUT,
  output logic [15:0] PSW_OUT,
  output logic [15:0] VECTOR_ADDR_OUT,
  output logic IRQ_PENDING_OUT,
  output logic [3:0] ACTIVE_SRC_OUT,
  output logic [1:0] CURRENT_PRIORITY_FIELD_OUT
);
  import intc_pkg::*;

  // --------------------------------------------------------------
  // level registers
  // --------------------------------------------------------------
  logic [2*N-1:0] lvl_q;
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      lvl_q <= {N{LVL_RESET}};
    else if (LEVEL_WRITE_IN)
      lvl_q <= {LEVEL_SELECT_REG_C_IN, LEVEL_SELECT_REG_B_IN, LEVEL_SELECT_REG_A_IN};
  end

  // --------------------------------------------------------------
  // request gathering
  // --------------------------------------------------------------
  logic [N-1:0] req;
  always_comb
  begin
    req = PERIPH_REQ_IN & SRC_USED;
    req[SRC_EXT0] = EXT0_FLAG_IN && EXT0_ENABLE_IN;
    req[SRC_EXT1] = EXT_PIN1_REQUEST_FLAG_IN && EXT_PIN1_REQUEST_ENABLE_IN;
    req[SRC_WATCH] = PERIPH_REQ_IN[SRC_WATCH] && !MAIN_STOP_IN;
  end

  logic win_v;
  logic [3:0] win_src;
  logic [1:0] win_lvl;
  intc_arbiter #(.N(N)) u_arb (
    .req_in(req),
    .lvl_in(lvl_q),
    .valid_out(win_v),
    .src_out(win_src),
    .lvl_out(win_lvl)
  );

  // --------------------------------------------------------------
  // acceptance
  // --------------------------------------------------------------
  logic [1:0] cur_lvl;
  logic gie;
  logic accept;
  assign cur_lvl = PROGRAM_STATUS_WORD_IN[IL_LSB +: 2];
  assign gie = PROGRAM_STATUS_WORD_IN[IFLAG_BIT];
  cpu_state_type state_q;
  assign accept = (state_q == ST_RUN) && INSTR_BOUNDARY_IN && win_v && gie
                  && (win_lvl < cur_lvl);

  // --------------------------------------------------------------
  // entry / return sequence
  // --------------------------------------------------------------
  logic [15:0] save_pc_q;
  logic [15:0] save_psw_q;
  logic [3:0] src_q;
  logic [1:0] lvl_acc_q;
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      state_q <= ST_RUN;
    else
    begin
      case (state_q)
        ST_RUN:
          if (accept)
            state_q <= ST_PUSH_PC;
          else if (INSTR_BOUNDARY_IN && RETURN_FROM_INTERRUPT_OP_IN)
            state_q <= ST_POP_PSW;
        ST_PUSH_PC: state_q <= ST_PUSH_PSW;
        ST_PUSH_PSW: state_q <= ST_VECTOR;
        ST_VECTOR: state_q <= ST_RUN;
        ST_POP_PSW: state_q <= ST_POP_PC;
        ST_POP_PC: state_q <= ST_RUN;
        default: state_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      save_pc_q <= PC_RESET;
      save_psw_q <= PSW_RESET;
      src_q <= 4'h0;
      lvl_acc_q <= CUR_LVL_RESET;
    end
    else if (accept)
    begin
      // PC, status, winning source and level are captured; accumulators stay with the core
      save_pc_q <= PC_IN;
      save_psw_q <= PROGRAM_STATUS_WORD_IN;
      src_q <= win_src;
      lvl_acc_q <= win_lvl;
    end
  end

  // --------------------------------------------------------------
  // outputs to the core
  // --------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      STACK_WRITE_OUT <= 1'b0;
      STACK_READ_OUT <= 1'b0;
      STACK_WDATA_OUT <= 16'h0000;
      LOAD_PC_OUT <= 1'b0;
      PC_OUT <= PC_RESET;
      LOAD_PSW_OUT <= 1'b0;
      PSW_OUT <= PSW_RESET;
      VECTOR_ADDR_OUT <= 16'h0000;
      CURRENT_PRIORITY_FIELD_OUT <= CUR_LVL_RESET;
    end
    else
    begin
      CURRENT_PRIORITY_FIELD_OUT <= cur_lvl;
      STACK_WRITE_OUT <= (state_q == ST_PUSH_PC) || (state_q == ST_PUSH_PSW);
      STACK_READ_OUT <= (state_q == ST_POP_PSW) || (state_q == ST_POP_PC);
      STACK_WDATA_OUT <= (state_q == ST_PUSH_PC) ? save_pc_q : save_psw_q;
      LOAD_PC_OUT <= (state_q == ST_VECTOR) || (state_q == ST_POP_PC);
      LOAD_PSW_OUT <= (state_q == ST_VECTOR) || (state_q == ST_POP_PSW);
      if (state_q == ST_VECTOR)
      begin
        VECTOR_ADDR_OUT <= VEC_TOP - 16'({src_q, 1'b0});
        PC_OUT <= VEC_TOP - 16'({src_q, 1'b0});
        PSW_OUT <= {save_psw_q[15:14], lvl_acc_q, save_psw_q[11:0]};
      end
      else if (state_q == ST_POP_PSW)
        PSW_OUT <= STACK_RDATA_IN;
      else if (state_q == ST_POP_PC)
        PC_OUT <= STACK_RDATA_IN;
    end
  end

  assign SUSPEND_OUT = (state_q != ST_RUN);
  assign IRQ_PENDING_OUT = win_v;
  assign ACTIVE_SRC_OUT = src_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_reset_off;
    @(posedge CLK_IN) $fell(RST_IN) |-> !win_v;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("request after reset");

  property p_lvl3_never;
    @(posedge CLK_IN) disable iff (RST_IN) win_v |-> win_lvl != LVL_OFF;
  endproperty
  a_lvl3_never: assert property (p_lvl3_never) else $error("level 3 forwarded");

  property p_src_valid;
    @(posedge CLK_IN) disable iff (RST_IN) win_v |-> req[win_src];
  endproperty
  a_src_valid: assert property (p_src_valid) else $error("winner not pending");

  property p_accept_cond;
    @(posedge CLK_IN) disable iff (RST_IN)
      (state_q == ST_PUSH_PC) |-> $past(gie) && ($past(win_lvl) < $past(cur_lvl));
  endproperty
  a_accept_cond: assert property (p_accept_cond) else $error("bad accept");

  property p_entry_seq;
    @(posedge CLK_IN) disable iff (RST_IN)
      accept |=> ##1 STACK_WRITE_OUT ##1 STACK_WRITE_OUT ##1 (LOAD_PC_OUT && LOAD_PSW_OUT);
  endproperty
  a_entry_seq: assert property (p_entry_seq) else $error("entry sequence wrong");

  property p_vector;
    @(posedge CLK_IN) disable iff (RST_IN)
      accept |-> ##4 (PC_OUT == VEC_TOP - 16'({$past(win_src, 4), 1'b0}));
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");

  property p_level_set;
    @(posedge CLK_IN) disable iff (RST_IN)
      accept |-> ##4 (PSW_OUT[IL_LSB +: 2] == $past(win_lvl, 4));
  endproperty
  a_level_set: assert property (p_level_set) else $error("level not stored");

  property p_return;
    @(posedge CLK_IN) disable iff (RST_IN)
      (state_q == ST_RUN && INSTR_BOUNDARY_IN && RETURN_FROM_INTERRUPT_OP_IN && !accept)
      |=> ##1 STACK_READ_OUT ##1 (STACK_READ_OUT && LOAD_PC_OUT);
  endproperty
  a_return: assert property (p_return) else $error("return sequence wrong");

  property p_watch_stop;
    @(posedge CLK_IN) disable iff (RST_IN)
      MAIN_STOP_IN |-> !(win_v && (win_src == 4'(SRC_WATCH)));
  endproperty
  a_watch_stop: assert property (p_watch_stop) else $error("watch in stop");

  c_accept: cover property (@(posedge CLK_IN) disable iff (RST_IN) accept);
  c_return: cover property (@(posedge CLK_IN) disable iff (RST_IN) state_q == ST_POP_PC);
  c_tie: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    accept && req[0] && req[1] && lvl_q[1:0] == lvl_q[3:2]);
endmodule
`default_nettype wire

// File: stack_model.sv
`default_nettype none
module stack_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  output logic [2:0] depth_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_q [0:7];
  logic [2:0] depth_q;
  // words come back last in, first out
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      depth_q <= 3'h0;
    else if (push_in)
    begin
      mem_q[depth_q] <= wdata_in;
      depth_q <= depth_q + 3'h1;
    end
    else if (pop_in)
      depth_q <= depth_q - 3'h1;
  end
  // read data is the next word not yet claimed by a pop strobe: the
  // controller samples it one cycle before its own pop strobe appears
  logic [2:0] top_idx;
  logic avail;
  assign top_idx = depth_q - 3'h1 - {2'h0, pop_in};
  assign avail = depth_q > {2'h0, pop_in};
  // an empty stack shows a toggling pattern, never a stale word
  assign rdata_out = avail ? mem_q[top_idx] : {8{clk_in, ~clk_in}};
  assign depth_out = depth_q;
endmodule
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import intc_pkg::*;
  typedef struct packed {logic [23:0] l; logic [11:0] r; logic [3:0] s; logic [1:0] v;} row_type;
  row_type rows [5] = '{
    '{24'haaaaaa, 12'h009, 4'h0, 2'h2},
    '{24'h555557, 12'h003, 4'h1, 2'h1},
    '{24'h7fffbf, 12'h808, 4'hb, 2'h1},
    '{24'hfbffdf, 12'h204, 4'h9, 2'h2},
    '{24'hfffd7f, 12'h018, 4'h3, 2'h1}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] req = 12'h000;
  logic stop = 1'b0;
  logic wr = 1'b0;
  logic bnd = 1'b1;
  logic ret = 1'b0;
  logic en = 1'b1;
  logic [23:0] lv = 24'hffffff;
  logic [15:0] pc = 16'h1230;
  logic [15:0] psw = 16'h38a5;
  logic susp, sw, sr, lpc, lpsw, pend;
  logic [15:0] wd, pco, pswo, vec, rd;
  logic [3:0] src;
  logic [1:0] cur;
  logic [2:0] depth;
  int err_count = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  priority_interrupt_controller u_priority_interrupt_controller (
    .CLK_IN(clk), .RST_IN(rst), .PERIPH_REQ_IN(req),
    .EXT0_FLAG_IN(req[0]), .EXT0_ENABLE_IN(en),
    .EXT_PIN1_REQUEST_FLAG_IN(req[1]), .EXT_PIN1_REQUEST_ENABLE_IN(en),
    .MAIN_STOP_IN(stop), .LEVEL_SELECT_REG_A_IN(lv[7:0]),
    .LEVEL_SELECT_REG_B_IN(lv[15:8]), .LEVEL_SELECT_REG_C_IN(lv[23:16]),
    .LEVEL_WRITE_IN(wr), .INSTR_BOUNDARY_IN(bnd), .RETURN_FROM_INTERRUPT_OP_IN(ret),
    .PC_IN(pc), .PROGRAM_STATUS_WORD_IN(psw), .STACK_RDATA_IN(rd),
    .SUSPEND_OUT(susp), .STACK_WRITE_OUT(sw), .STACK_READ_OUT(sr),
    .STACK_WDATA_OUT(wd), .LOAD_PC_OUT(lpc), .PC_OUT(pco), .LOAD_PSW_OUT(lpsw),
    .PSW_OUT(pswo), .VECTOR_ADDR_OUT(vec), .IRQ_PENDING_OUT(pend),
    .ACTIVE_SRC_OUT(src), .CURRENT_PRIORITY_FIELD_OUT(cur));
  stack_model u_stack_model (.clk_in(clk), .rst_in(rst), .push_in(sw), .pop_in(sr),
    .wdata_in(wd), .rdata_out(rd), .depth_out(depth));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wait_load();
    int k;
    k = 0;
    while (lpc !== 1'b1 && k < 20)
    begin
      step();
      k++;
    end
    if (lpc !== 1'b1)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic set_lv(input logic [23:0] l);
    lv = l;
    wr = 1'b1;
    step();
    wr = 1'b0;
  endtask
  task automatic expect_idle(input string what);
    repeat (6)
    begin
      step();
      chk(what, 16'h0000, {15'h0000, susp});
    end
  endtask
  task automatic run_case(input logic [23:0] l, input logic [11:0] r, input logic [3:0] s,
    input logic [1:0] v);
    logic [15:0] spc, spsw;
    spc = pc;
    spsw = psw;
    set_lv(l);
    req = r;
    wait_load();
    chk("vector", VEC_TOP - VEC_STEP * s, vec);
    chk("source", {12'h000, s}, {12'h000, src});
    chk("new status", {spsw[15:14], v, spsw[11:0]}, pswo);
    chk("saved status", spsw, rd);
    chk("stack depth", 16'h0002, {13'h0000, depth});
    chk("entry pc", VEC_TOP - VEC_STEP * s, pco);
    chk("status load", 16'h0001, {15'h0000, lpsw});
    psw = pswo;
    pc = pco;
    req = 12'h000;
    step();
    chk("current level", {14'h0000, v}, {14'h0000, cur});
    ret = 1'b1;
    step();
    ret = 1'b0;
    wait_load();
    chk("restored pc", spc, pco);
    chk("restored status", spsw, pswo);
    psw = pswo;
    pc = spc + 16'h0102;
    step();
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    req = 12'hfff;
    expect_idle("reset idle");
    chk("pending", 16'h0000, {15'h0000, pend});
    req = 12'h000;
    step();
    foreach (rows[i])
      run_case(rows[i].l, rows[i].r, rows[i].s, rows[i].v);
    for (int s = 0; s < NUM_SRC; s++)
      if (SRC_USED[s])
        run_case(24'hffffff & ~(24'h2 << (2 * s)), 12'h001 << s, s[3:0], 2'h1);
    psw = 16'h30a5;
    set_lv(24'h7fffff);
    req = 12'h800;
    expect_idle("global enable off");
    chk("pending held", 16'h0001, {15'h0000, pend});
    psw = 16'h18a5;
    expect_idle("level not more urgent");
    req = 12'h000;
    psw = 16'h38a5;
    stop = 1'b1;
    step();
    req = 12'h800;
    expect_idle("stop mode watch");
    chk("watch pending", 16'h0000, {15'h0000, pend});
    req = 12'h000;
    en = 1'b0;
    set_lv(24'hfffff5);
    req = 12'h003;
    expect_idle("pin enable off");
    chk("pin pending off", 16'h0000, {15'h0000, pend});
    en = 1'b1;
    #1;
    chk("pin pending on", 16'h0001, {15'h0000, pend});
    report_and_stop();
  end
endmodule
`default_nettype wire
